// ===== rtl/emp_pkg.sv
// Package of constants for the external memory port pin block
package emp_pkg;
  localparam int ADDR_W          = 18;    // Address lines
  localparam int DATA_W          = 24;    // Data lines
  localparam int ATTR_W          = 4;     // Attribute / row strobe lines
  localparam int WAIT_W          = 4;     // Programmed wait-state field width
  localparam int OMR_PRIO_DIS_BIT = 14;   // Priority disable bit position
  localparam int OMR_W           = 24;    // Operating mode word width
  localparam int DRAM_MAX_MHZ    = 100;   // Highest core rate for DRAM access
  localparam int CORE_MHZ        = 125;   // Core clock rate
  localparam logic [3:0] IDLE_CNT = 4'h0; // Wait counter reset value
  // Access sequencer states, one-hot
  typedef enum logic [2:0] {
    EMP_IDLE   = 3'b001,
    EMP_ACCESS = 3'b010,
    EMP_FINISH = 3'b100
  } emp_state_type;
endpackage

// ===== rtl/emp_port.sv
// External memory expansion port pin logic
`timescale 1ns/100ps
`default_nettype none
module emp_port #(
  parameter int CORE_MHZ = emp_pkg::CORE_MHZ
) (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       bus_grant,
  input  wire logic                       low_power,
  input  wire logic [emp_pkg::OMR_W-1:0]  operating_mode_reg,
  input  wire logic [emp_pkg::WAIT_W-1:0] bus_control_reg,
  input  wire logic                       attr_dram_mode,
  input  wire logic [emp_pkg::ATTR_W-1:0] attr_polarity,
  input  wire logic                       req_valid,
  input  wire logic                       req_write,
  input  wire logic [emp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic [emp_pkg::DATA_W-1:0] req_wdata,
  input  wire logic [emp_pkg::ATTR_W-1:0] req_attr,
  input  wire logic                       transfer_ack_n,
  input  wire logic [emp_pkg::DATA_W-1:0] data_in,
  output logic                            req_ready,
  output logic                            resp_valid,
  output logic [emp_pkg::DATA_W-1:0]      resp_rdata,
  output logic [emp_pkg::ADDR_W-1:0]      addr_out,
  output logic                            addr_oe_n,
  output logic [emp_pkg::DATA_W-1:0]      data_out,
  output logic                            data_oe_n,
  output logic [emp_pkg::ATTR_W-1:0]      attr_select_lines,
  output logic                            attr_oe_n,
  output logic                            read_n,
  output logic                            write_n,
  output logic                            strobe_oe_n,
  output logic                            bus_busy_n,
  output logic                            busy_oe_n
);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  // DRAM row strobes are only allowed at or below the limit rate
  localparam bit DRAM_OK = (CORE_MHZ <= emp_pkg::DRAM_MAX_MHZ);
  // Extra finish cycles of a read while the data synchroniser fills
  localparam logic [emp_pkg::WAIT_W-1:0] RD_SYNC_WAIT = 4'h1;

  // Keep only the lowest set attribute bit
  function automatic logic [emp_pkg::ATTR_W-1:0] one_hot_low(
    input logic [emp_pkg::ATTR_W-1:0] v);
    logic [emp_pkg::ATTR_W-1:0] r;
    r = v & (~v + 4'h1);
    return r;
  endfunction

  // --------------------------------------------------------------
  // Synchronisers for pin inputs
  // --------------------------------------------------------------
  logic [1:0]                  ack_sync;    // Acknowledge, two flops
  logic [emp_pkg::DATA_W-1:0]  din_s1;      // Data in, first flop
  logic [emp_pkg::DATA_W-1:0]  din_s2;      // Data in, second flop
  logic [1:0]                  grant_sync;  // Bus grant, two flops

  // Two-stage capture of external pins
  always_ff @(posedge clock) begin
    if (srst) begin
      ack_sync   <= 2'h3;
      grant_sync <= 2'h0;
      din_s1     <= 24'h0;
      din_s2     <= 24'h0;
    end else begin
      ack_sync   <= {ack_sync[0], transfer_ack_n};
      grant_sync <= {grant_sync[0], bus_grant};
      din_s1     <= data_in;
      din_s2     <= din_s1;
    end
  end

  logic ack_n_s;  // Synchronised acknowledge, active low
  logic master;   // Device owns the bus
  assign ack_n_s = ack_sync[1];
  assign master  = grant_sync[1] & ~low_power;

  // --------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------
  emp_pkg::emp_state_type      state;       // Current state
  emp_pkg::emp_state_type      next_state;  // Next state
  logic [emp_pkg::WAIT_W-1:0]  wait_cnt;    // Programmed waits left
  logic [emp_pkg::WAIT_W-1:0]  next_wait_cnt;
  logic                        waited;      // Access had waits
  logic                        next_waited;
  logic                        is_write;    // Current access is a write
  logic                        next_is_write;
  logic [emp_pkg::ADDR_W-1:0]  next_addr_out;
  logic [emp_pkg::DATA_W-1:0]  next_data_out;
  logic [emp_pkg::ATTR_W-1:0]  attr_raw;    // Attribute before polarity
  logic [emp_pkg::ATTR_W-1:0]  next_attr_raw;
  logic                        next_read_n;
  logic                        next_write_n;
  logic                        next_resp_valid;
  logic [emp_pkg::DATA_W-1:0]  next_resp_rdata;
  logic                        next_req_ready;
  logic [emp_pkg::ATTR_W-1:0]  attr_sel;    // Priority-filtered request

  // Next-state logic of the sequencer
  always_comb begin
    next_state      = state;
    next_wait_cnt   = wait_cnt;
    next_waited     = waited;
    next_is_write   = is_write;
    next_addr_out   = addr_out;
    next_data_out   = data_out;
    next_attr_raw   = attr_raw;
    next_read_n     = 1'b1;
    next_write_n    = 1'b1;
    next_resp_valid = 1'b0;
    next_resp_rdata = resp_rdata;
    next_req_ready  = 1'b0;
    // Priority unless disabled by the mode word
    if (operating_mode_reg[emp_pkg::OMR_PRIO_DIS_BIT]) begin
      attr_sel = req_attr;
    end else begin
      attr_sel = one_hot_low(req_attr);
    end
    // Row strobe use suppressed above the DRAM rate limit
    if (attr_dram_mode && !DRAM_OK) begin
      attr_sel = 4'h0;
    end
    case (state)
      emp_pkg::EMP_IDLE: begin
        next_req_ready = master;
        // Address left alone while idle
        if (master && req_valid && req_ready) begin
          next_state    = emp_pkg::EMP_ACCESS;
          next_addr_out = req_addr;
          next_data_out = req_wdata;
          next_attr_raw = attr_sel;
          next_is_write = req_write;
          next_wait_cnt = bus_control_reg;
          next_waited   = (bus_control_reg != emp_pkg::IDLE_CNT);
          next_req_ready = 1'b0;
          // Exactly one strobe per access
          next_read_n   = req_write;
          next_write_n  = ~req_write;
        end
      end
      emp_pkg::EMP_ACCESS: begin
        next_read_n  = is_write;
        next_write_n = ~is_write;
        if (!master) begin
          next_state = emp_pkg::EMP_IDLE;
          next_read_n  = 1'b1;
          next_write_n = 1'b1;
        end else if (wait_cnt != emp_pkg::IDLE_CNT) begin
          next_wait_cnt = wait_cnt - 4'h1;
        end else if (!waited || !ack_n_s) begin
          next_state      = emp_pkg::EMP_FINISH;
          next_read_n     = 1'b1;
          next_write_n    = 1'b1;
          next_resp_valid = is_write;
          next_wait_cnt   = is_write ? emp_pkg::IDLE_CNT : RD_SYNC_WAIT;
          next_attr_raw   = 4'h0;
        end
      end
      emp_pkg::EMP_FINISH: begin
        // Reads wait here until the bus word has crossed both data flops
        if (wait_cnt != emp_pkg::IDLE_CNT) begin
          next_wait_cnt = wait_cnt - 4'h1;
        end else begin
          next_state      = emp_pkg::EMP_IDLE;
          next_req_ready  = master;
          next_resp_valid = ~is_write;
          next_resp_rdata = is_write ? resp_rdata : din_s2;
        end
      end
      default: begin
        next_state = emp_pkg::EMP_IDLE;
      end
    endcase
  end

  // Register the sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      state      <= emp_pkg::EMP_IDLE;
      wait_cnt   <= emp_pkg::IDLE_CNT;
      waited     <= 1'b0;
      is_write   <= 1'b0;
      addr_out   <= 18'h0;
      data_out   <= 24'h0;
      attr_raw   <= 4'h0;
      read_n     <= 1'b1;
      write_n    <= 1'b1;
      resp_valid <= 1'b0;
      resp_rdata <= 24'h0;
      req_ready  <= 1'b0;
    end else begin
      state      <= next_state;
      wait_cnt   <= next_wait_cnt;
      waited     <= next_waited;
      is_write   <= next_is_write;
      addr_out   <= next_addr_out;
      data_out   <= next_data_out;
      attr_raw   <= next_attr_raw;
      read_n     <= next_read_n;
      write_n    <= next_write_n;
      resp_valid <= next_resp_valid;
      resp_rdata <= next_resp_rdata;
      req_ready  <= next_req_ready;
    end
  end

  // --------------------------------------------------------------
  // Output enables and line polarity
  // --------------------------------------------------------------
  logic                        next_addr_oe_n;
  logic                        next_data_oe_n;
  logic                        next_ctl_oe_n;
  logic [emp_pkg::ATTR_W-1:0]  next_attr;

  // Enables follow mastership; data drives only for writes
  always_comb begin
    next_addr_oe_n = ~master;
    next_ctl_oe_n  = ~master;
    // Data drives on writes; while off, data_out keeps its value until the next request (read or write) loads req_wdata
    next_data_oe_n = ~(master && (next_state == emp_pkg::EMP_ACCESS)
                       && next_is_write);
    // Row strobe polarity per line in DRAM mode, else active high
    if (attr_dram_mode) begin
      next_attr = next_attr_raw ^ attr_polarity;
    end else begin
      next_attr = next_attr_raw;
    end
  end

  // Register enables, attribute pins and busy indication
  always_ff @(posedge clock) begin
    if (srst) begin
      addr_oe_n         <= 1'b1;
      data_oe_n         <= 1'b1;
      strobe_oe_n       <= 1'b1;
      attr_oe_n         <= 1'b1;
      busy_oe_n         <= 1'b1;
      bus_busy_n        <= 1'b1;
      attr_select_lines <= 4'h0;
    end else begin
      addr_oe_n         <= next_addr_oe_n;
      data_oe_n         <= next_data_oe_n;
      strobe_oe_n       <= next_ctl_oe_n;
      attr_oe_n         <= next_ctl_oe_n;
      busy_oe_n         <= next_ctl_oe_n;
      bus_busy_n        <= ~master;
      attr_select_lines <= next_attr;
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  strobe_excl_a: assert property (!(!read_n && !write_n))
    else $error("read and write strobes both asserted");
  lowpwr_tristate_a: assert property (low_power |=>
      (addr_oe_n && data_oe_n && strobe_oe_n && attr_oe_n && busy_oe_n))
    else $error("pins not released in low power");
  addr_hold_a: assert property ((state == emp_pkg::EMP_IDLE)
      && !(req_valid && req_ready) |=> $stable(addr_out))
    else $error("address changed while idle");
  prio_onehot_a: assert property (
      !operating_mode_reg[emp_pkg::OMR_PRIO_DIS_BIT] && !attr_dram_mode
      && $stable(operating_mode_reg) && !$past(attr_dram_mode)
      |-> $onehot0(attr_select_lines))
    else $error("more than one attribute asserted");
  data_keep_a: assert property ($rose(data_oe_n) |=>
      $stable(data_out))
    else $error("keeper value changed");
  nowait_len_a: assert property ($fell(read_n) && !waited
      && master ##1 master |-> ##0 $rose(read_n))
    else $error("zero wait read was stretched");
  wait_min_a: assert property ($fell(write_n) && wait_cnt == 4'h2
      |=> !write_n [*2])
    else $error("write ended before programmed waits");
  read_oe_a: assert property (!read_n |-> !strobe_oe_n)
    else $error("read asserted while strobe released");
  addr_oe_a: assert property (!master |=> addr_oe_n)
    else $error("address driven while not master");

  read_c: cover property ($fell(read_n) ##[1:20] resp_valid);
  write_c: cover property ($fell(write_n) ##[1:20] resp_valid);
  ackwait_c: cover property (state == emp_pkg::EMP_ACCESS && waited
      && wait_cnt == 4'h0 && ack_n_s [*3]);
  allattr_c: cover property (attr_select_lines == 4'hf);
endmodule
`default_nettype wire

// ===== sim/emp_mem_model.sv
// Behavioural external memory standing on the far side of the port pins
`timescale 1ns/100ps
`default_nettype none
module emp_mem_model (
  input  wire logic                       clock,
  input  wire logic [emp_pkg::ADDR_W-1:0] addr_out,
  input  wire logic [emp_pkg::DATA_W-1:0] data_out,
  input  wire logic                       data_oe_n,
  input  wire logic                       read_n,
  input  wire logic                       write_n,
  input  wire logic                       strobe_oe_n,
  input  wire logic [7:0]                 ack_delay,
  output var  logic [emp_pkg::DATA_W-1:0] data_in,
  output var  logic                       transfer_ack_n
);
  // ------------------------------------------------------------
  // Storage and strobe tracking
  // ------------------------------------------------------------
  logic [emp_pkg::DATA_W-1:0] mem [16]; // Small word store
  logic [emp_pkg::DATA_W-1:0] junk;     // Pattern for an undriven bus
  logic [7:0]                 low_cnt;  // Cycles a strobe has been low
  logic                       active;   // A strobe is driven low
  assign active = (read_n === 1'b0 || write_n === 1'b0)
                  && strobe_oe_n === 1'b0;
  // Read data only while selected, otherwise a changing pattern
  assign data_in = (active && read_n === 1'b0) ? mem[addr_out[3:0]] : junk;
  initial begin
    junk = 24'h5a5a5a;
    low_cnt = 8'h00;
    transfer_ack_n = 1'b1;
  end
  // Capture writes, count strobe time, answer with acknowledge
  always @(posedge clock) begin
    junk <= ~junk;
    if (active && write_n === 1'b0 && data_oe_n === 1'b0) begin
      mem[addr_out[3:0]] <= data_out;
    end
    low_cnt <= !active ? 8'h00 :
               (low_cnt == 8'hff) ? low_cnt : low_cnt + 8'h01;
    // Ack withheld at cycle start, then given
    transfer_ack_n <= !(active && low_cnt >= ack_delay);
  end
endmodule
`default_nettype wire

// ===== sim/tb_external_memory_port_pins.sv
// Self-checking bench for the external memory port pin block
`timescale 1ns/100ps
`default_nettype none
module tb_external_memory_port_pins;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        clock, srst, bus_grant, low_power, attr_dram_mode, req_valid;
  logic        req_write, transfer_ack_n, req_ready, resp_valid, read_n;
  logic        write_n, addr_oe_n, data_oe_n, attr_oe_n, strobe_oe_n;
  logic        bus_busy_n, busy_oe_n;
  logic [23:0] operating_mode_reg, req_wdata, data_in, resp_rdata, data_out;
  logic [3:0]  bus_control_reg, attr_polarity, req_attr, attr_select_lines;
  logic [17:0] req_addr, addr_out;
  logic [7:0]  ack_delay;
  int          err_count, samples_checked, cycles, lat;
  emp_port u_dut (.clock(clock), .srst(srst), .bus_grant(bus_grant),
    .low_power(low_power), .operating_mode_reg(operating_mode_reg),
    .bus_control_reg(bus_control_reg), .attr_dram_mode(attr_dram_mode),
    .attr_polarity(attr_polarity), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_attr(req_attr), .transfer_ack_n(transfer_ack_n),
    .data_in(data_in), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp_rdata(resp_rdata), .addr_out(addr_out), .addr_oe_n(addr_oe_n),
    .data_out(data_out), .data_oe_n(data_oe_n),
    .attr_select_lines(attr_select_lines), .attr_oe_n(attr_oe_n),
    .read_n(read_n), .write_n(write_n), .strobe_oe_n(strobe_oe_n),
    .bus_busy_n(bus_busy_n), .busy_oe_n(busy_oe_n));
  emp_mem_model u_mem (.clock(clock), .addr_out(addr_out),
    .data_out(data_out), .data_oe_n(data_oe_n), .read_n(read_n),
    .write_n(write_n), .strobe_oe_n(strobe_oe_n), .ack_delay(ack_delay),
    .data_in(data_in), .transfer_ack_n(transfer_ack_n));
  // ------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Cut a hang short after a generous cycle budget
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One access; pins judged in the first strobe cycle
  task automatic access(input logic wr, input logic [17:0] a,
                        input logic [23:0] d, input logic [3:0] at,
                        input logic [3:0] at_exp);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clock);
      n++;
    end
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_attr = at;
    req_valid = 1'b1;
    @(negedge clock);
    req_valid = 1'b0;
    // Strobe cycle: pins launched by the edge that took the request
    chk("addr_out", a, addr_out);
    chk("strobes", {wr, !wr}, {read_n, write_n});
    chk("attr_lines", at_exp, attr_select_lines);
    chk("drive_en", 4'h0,
        {addr_oe_n, attr_oe_n, strobe_oe_n, busy_oe_n});
    chk("busy_n", 1'b0, bus_busy_n);
    chk("data_oe_n", wr ? 1'b0 : 1'b1, data_oe_n);
    if (wr) chk("data_out", d, data_out);
    lat = 0;
    while (resp_valid !== 1'b1 && lat < 200) begin
      @(negedge clock);
      lat++;
    end
    // Response stands for one cycle only
    @(negedge clock);
    chk("resp_pulse", 1'b0, resp_valid);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_transfers();
    bus_control_reg = 4'h0;
    ack_delay = 8'hff;
    access(1'b1, 18'h2a5c3, 24'hc3a51e, 4'h1, 4'h1);
    chk("w0_write_lat", 1, lat);
    access(1'b0, 18'h2a5c3, 24'h000000, 4'h2, 4'h2);
    chk("w0_read_lat", 3, lat);
    chk("rdata", 24'hc3a51e, resp_rdata);
    $display("test transfers done");
  endtask
  task automatic t_waits();
    bus_control_reg = 4'h2;
    ack_delay = 8'h00;
    access(1'b1, 18'h00005, 24'h5e17a0, 4'h1, 4'h1);
    chk("prog_wait_wr", 4, lat);
    bus_control_reg = 4'h4;
    access(1'b0, 18'h00005, 24'h0, 4'h1, 4'h1);
    chk("prog_wait_lat", 7, lat);
    chk("wait_rdata", 24'h5e17a0, resp_rdata);
    bus_control_reg = 4'h2;
    ack_delay = 8'h0c;
    access(1'b0, 18'h00006, 24'h0, 4'h1, 4'h1);
    chk("ack_wait_longer", 1, lat > 12 && lat < 24);
    bus_control_reg = 4'h0;
    $display("test waits done");
  endtask
  task automatic t_attr();
    for (int attr_priority_disable = 0; attr_priority_disable < 2; attr_priority_disable++) begin
      operating_mode_reg[14] = attr_priority_disable[0];
      access(1'b0, 18'h00007, 24'h0, 4'hc,
             attr_priority_disable ? 4'hc : 4'h4);
    end
    // Row strobes stay at their inactive level above the DRAM rate
    attr_dram_mode = 1'b1;
    attr_polarity = 4'h5;
    access(1'b0, 18'h00008, 24'h0, 4'h3, 4'h5);
    attr_dram_mode = 1'b0;
    attr_polarity = 4'h0;
    operating_mode_reg = 24'h000000;
    $display("test attributes done");
  endtask
  task automatic t_release();
    access(1'b1, 18'h1f00a, 24'h9e61b4, 4'h1, 4'h1);
    repeat (4) @(negedge clock);
    chk("idle_addr", 18'h1f00a, addr_out);
    low_power = 1'b1;
    repeat (4) @(negedge clock);
    chk("stop_oe", 5'h1f, {addr_oe_n, data_oe_n, attr_oe_n, strobe_oe_n,
        busy_oe_n});
    chk("stop_ready", 1'b0, req_ready);
    chk("keeper", 24'h9e61b4, data_out);
    low_power = 1'b0;
    bus_grant = 1'b0;
    repeat (6) @(negedge clock);
    chk("slave_oe", 5'h1f, {addr_oe_n, data_oe_n, attr_oe_n, strobe_oe_n,
        busy_oe_n});
    bus_grant = 1'b1;
    access(1'b0, 18'h1f00a, 24'h0, 4'h1, 4'h1);
    chk("regain_rdata", 24'h9e61b4, resp_rdata);
    $display("test release done");
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {srst, bus_grant, low_power, attr_dram_mode, req_valid, req_write} = 6'h30;
    ack_delay = 8'hff;
    operating_mode_reg = 24'h000000;
    {bus_control_reg, attr_polarity, req_attr} = 12'h000;
    req_addr = 18'h00000;
    req_wdata = 24'h000000;
    repeat (12) @(negedge clock);
    chk("reset_oe", 5'h1f, {addr_oe_n, data_oe_n, attr_oe_n, strobe_oe_n,
        busy_oe_n});
    srst = 1'b0;
    t_transfers();
    t_waits();
    t_attr();
    t_release();
    complete_run();
  end
endmodule
`default_nettype wire
